// ===== mlsc_chk.sv
`timescale 1ns/1ns
module mlsc_chk import mlsc_pkg::*; #(
  parameter int PULSE_CYC = RESET_PULSE_CYC
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // pins watched
  input wire logic I_MODULE_SELECT_N,
  input wire logic I_MODULE_INIT_N,
  input wire logic [7:1] I_FAULT,
  input wire logic O_SDA,
  input wire logic O_SDA_OE_N,
  input wire logic O_PRESENCE_N,
  input wire logic O_ATTENTION_N,
  input wire logic O_ATTENTION_OE_N,
  input wire logic O_IN_RESET
);
  logic [15:0] low_cnt;
  logic long_seen;
  logic [15:0] next_low_cnt;
  logic next_long_seen;
  // raw length of the init pulse; long_seen kept until the reset shows
  always_comb begin
    next_low_cnt = (I_RESET | I_MODULE_INIT_N) ? 16'h0000 : low_cnt + {15'h0000, low_cnt != 16'hffff};
    next_long_seen = ~I_RESET & ~O_IN_RESET & (long_seen | (low_cnt >= 16'(PULSE_CYC)));
  end
  always_ff @(posedge I_MCLK) begin
    low_cnt <= next_low_cnt;
    long_seen <= next_long_seen;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  sequence ready_seq;
    $fell(O_IN_RESET);
  endsequence
  sequence attn_seq;
    ##[0:3] !O_ATTENTION_OE_N;
  endsequence
  presence_tied_a: assert property (O_PRESENCE_N == 1'b0) else $error("presence released");
  attn_no_high_a: assert property (O_ATTENTION_N == 1'b0) else $error("attention driven high");
  sda_no_high_a: assert property (O_SDA == 1'b0) else $error("data driven high");
  deselect_quiet_a: assert property (I_MODULE_SELECT_N [*6] |-> O_SDA_OE_N) else $error("answered unselected");
  short_init_a: assert property ($rose(O_IN_RESET) |-> long_seen) else $error("reset on short pulse");
  long_init_a: assert property (low_cnt == 16'(PULSE_CYC + 3) |-> ##[0:6] O_IN_RESET) else $error("no reset");
  ready_attn_a: assert property (ready_seq |-> attn_seq) else $error("no completion attention");
  fault_attn_a: assert property ($rose(|I_FAULT) |-> ##[1:6] !O_ATTENTION_OE_N) else $error("fault unflagged");
endmodule
bind mlsc_top mlsc_chk #(.PULSE_CYC(PULSE_CYC)) chk (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
  .I_MODULE_SELECT_N(I_MODULE_SELECT_N), .I_MODULE_INIT_N(I_MODULE_INIT_N), .I_FAULT(I_FAULT),
  .O_SDA(O_SDA), .O_SDA_OE_N(O_SDA_OE_N), .O_PRESENCE_N(O_PRESENCE_N), .O_ATTENTION_N(O_ATTENTION_N),
  .O_ATTENTION_OE_N(O_ATTENTION_OE_N), .O_IN_RESET(O_IN_RESET));

// ===== mlsc_host.sv
`timescale 1ns/1ns
module mlsc_host import mlsc_pkg::*; (
  // device half of the data line
  input wire logic dev_sda,
  input wire logic dev_sda_oe_n,
  // bus lines as seen by the device
  output logic scl,
  output logic sda
);
  logic drv;
  // pull-up wins unless a party pulls low
  assign sda = drv & (dev_sda_oe_n | dev_sda);
  initial begin
    scl = 1'b1; // clock stands high between frames
    drv = 1'b1;
  end
  task automatic start();
    drv = 1'b1;
    // the device lets go of an ack some cycles after the clock falls
    #300 scl = 1'b1;
    #100 drv = 1'b0;
    #100 scl = 1'b0;
  endtask
  task automatic stop();
    drv = 1'b0;
    #100 scl = 1'b1;
    #100 drv = 1'b1;
    #100;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #100 drv = tx[i];
      #100 scl = 1'b1;
      #100 rx[i] = sda;
      #100 scl = 1'b0;
    end
  endtask
  task automatic put(input logic [7:0] ptr, input logic [7:0] data, output logic acked);
    logic [8:0] r0, r1, r2;
    start();
    bits({DEV_ADDR, 1'b0, 1'b1}, r0);
    bits({ptr, 1'b1}, r1);
    bits({data, 1'b1}, r2);
    stop();
    acked = ~(r0[0] | r1[0] | r2[0]);
  endtask
  // pointer write, repeated start, one byte ended by nack
  task automatic get(input logic [7:0] ptr, output logic [7:0] data, output logic acked);
    logic [8:0] r0, r1, r2, r3;
    start();
    bits({DEV_ADDR, 1'b0, 1'b1}, r0);
    bits({ptr, 1'b1}, r1);
    start();
    bits({DEV_ADDR, 1'b1, 1'b1}, r2);
    bits(9'h1ff, r3);
    stop();
    data = r3[8:1];
    acked = ~(r0[0] | r1[0] | r2[0]);
  endtask
endmodule

// ===== mlsc_mem.sv
`timescale 1ns/1ns
// general byte store, registered read data
module mlsc_mem import mlsc_pkg::*; #(
  parameter int AW = MEM_AW
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // no reset on the array; contents are user scratch
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== mlsc_pkg.sv
package mlsc_pkg;
  localparam int MCLK_HZ = 20000000;
  localparam int RESET_PULSE_MIN_US = 10;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_US * (MCLK_HZ / 1000000));
  localparam int MEM_AW = 8;
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // map locations of the status, flag, mask and control bytes
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h05;
  localparam int STATUS_NOT_READY_BIT = 0;
  localparam int FLAG_INIT_DONE_BIT = 0;
  localparam int CONTROL_LP_OVERRIDE_BIT = 0;
  localparam int CONTROL_LP_FORCE_BIT = 1;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sel_n;
    logic init_n;
    logic lp_sel;
  } pins_t;

  typedef struct packed {
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage

// ===== mlsc_top.sv
`timescale 1ns/1ns
module mlsc_top import mlsc_pkg::*; #(
  parameter int PULSE_CYC = RESET_PULSE_CYC
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // host control pins
  input wire logic I_MODULE_SELECT_N,
  input wire logic I_MODULE_INIT_N,
  input wire logic I_LOW_POWER_SELECT,
  // two-wire bus
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE_N,
  // status pins
  output logic O_PRESENCE_N,
  output logic O_ATTENTION_N,
  output logic O_ATTENTION_OE_N,
  // module side
  input wire logic [7:1] I_FAULT,
  output logic O_POWER_CAP,
  output logic O_IN_RESET
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK} bus_st_t;

  // two-stage synchronisers for the bus and host control pins; I_FAULT and I_RESET are used unsynchronised
  pins_t meta, sync, prev;
  always_ff @(posedge I_MCLK) begin
    meta <= '{I_SCL, I_SDA, I_MODULE_SELECT_N, I_MODULE_INIT_N, I_LOW_POWER_SELECT};
    sync <= meta;
    prev <= sync;
  end

  wire logic scl_rise = sync.scl & ~prev.scl;
  wire logic scl_fall = ~sync.scl & prev.scl;
  wire logic start_c = sync.scl & prev.scl & prev.sda & ~sync.sda;
  wire logic stop_c = sync.scl & prev.scl & ~prev.sda & sync.sda;
  wire logic selected = ~sync.sel_n;

  // init pulse qualifier
  logic [31:0] low_cnt, next_low_cnt;
  logic soft_rst, next_soft_rst;
  always_comb begin
    next_low_cnt = low_cnt;
    next_soft_rst = 1'b0;
    if (sync.init_n) begin
      next_low_cnt = 32'h0; // short pulses forgotten
    end else if (low_cnt < PULSE_CYC) begin
      next_low_cnt = low_cnt + 32'h1;
    end else begin
      next_soft_rst = 1'b1; // held long enough
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      low_cnt <= 32'h0;
      soft_rst <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      soft_rst <= next_soft_rst;
    end
  end
  wire logic any_rst = I_RESET | soft_rst;

  // bus engine and map registers
  bus_st_t st, next_st;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] ptr, next_ptr;
  logic first, next_first;
  logic rnw, next_rnw;
  logic sda_low, next_sda_low;
  logic not_ready, next_not_ready;
  logic [7:0] flags, next_flags;
  logic [7:0] mask, next_mask;
  logic [7:0] control, next_control;
  logic done_pend, next_done_pend;
  logic [7:0] mem_rdata;
  logic [7:0] rd_now;
  mem_req_t req;

  // read value at pointer
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] m);
    case (a)
      ADDR_STATUS: rd_byte = {7'h0, not_ready};
      ADDR_FLAGS: rd_byte = flags;
      ADDR_MASK: rd_byte = mask;
      ADDR_CONTROL: rd_byte = control;
      default: rd_byte = m;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_first = first;
    next_rnw = rnw;
    next_sda_low = sda_low;
    next_not_ready = not_ready;
    next_mask = mask;
    next_control = control;
    next_done_pend = 1'b0;
    // hardware sets after any clear below, so a new fault wins
    next_flags = flags;
    req = '{1'b0, ptr, shreg};
    // byte the host would see at the pointer right now
    rd_now = rd_byte(ptr, mem_rdata);
    if (stop_c || !selected) begin
      next_st = ST_IDLE;
      next_sda_low = 1'b0;
    end else if (start_c) begin
      next_st = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_low = 1'b0;
    end else begin
      case (st)
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sync.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (scl_fall && bit_cnt == 4'h8) begin
            next_bit_cnt = 4'h0;
            if (st == ST_ADDR) begin
              if (shreg[7:1] == DEV_ADDR) begin
                next_rnw = shreg[0];
                next_first = 1'b1;
                next_sda_low = 1'b1;
                next_st = ST_ACK;
              end else begin
                next_st = ST_IDLE;
              end
            end else begin
              next_sda_low = 1'b1;
              next_st = ST_WACK;
              if (first) begin
                next_ptr = shreg;
                next_first = 1'b0;
              end else begin
                req = '{1'b1, ptr, shreg};
                case (ptr)
                  ADDR_FLAGS: next_flags = flags & ~shreg;
                  ADDR_MASK: next_mask = shreg;
                  ADDR_CONTROL: next_control = shreg;
                  default: ;
                endcase
                next_ptr = ptr + 8'h1;
              end
            end
          end
        end
        ST_ACK, ST_WACK: begin
          if (scl_fall) begin
            if (rnw && st == ST_ACK) begin
              next_shreg = rd_now;
              next_sda_low = ~rd_now[7];
              next_bit_cnt = 4'h1;
              next_st = ST_RDATA;
            end else begin
              next_sda_low = 1'b0;
              next_st = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              next_sda_low = 1'b0;
              next_st = ST_RACK;
              if (ptr == ADDR_FLAGS) begin
                next_flags = flags & ~shreg; // clear on read
              end
              next_ptr = ptr + 8'h1;
            end else begin
              next_sda_low = ~shreg[7 - bit_cnt[2:0]];
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_first = sync.sda; // nack ends the read
          end
          if (scl_fall) begin
            if (first) begin
              next_st = ST_IDLE;
            end else begin
              next_shreg = rd_now;
              next_sda_low = ~rd_now[7];
              next_bit_cnt = 4'h1;
              next_st = ST_RDATA;
            end
          end
        end
        default: next_st = ST_IDLE;
      endcase
    end
    // completion posted after any clear, so it cannot be lost
    if (done_pend) begin
      next_not_ready = 1'b0;
      next_flags[FLAG_INIT_DONE_BIT] = 1'b1;
    end
    next_flags[7:1] = next_flags[7:1] | I_FAULT;
  end

  always_ff @(posedge I_MCLK) begin
    if (any_rst) begin
      st <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      first <= 1'b0;
      rnw <= 1'b0;
      sda_low <= 1'b0;
      not_ready <= 1'b1;
      flags <= 8'h00;
      mask <= MASK_RESET; // defaults restored
      control <= CONTROL_RESET;
      done_pend <= 1'b1; // completion posted even at power-up
    end else begin
      st <= next_st;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      first <= next_first;
      rnw <= next_rnw;
      sda_low <= next_sda_low;
      not_ready <= next_not_ready;
      flags <= next_flags;
      mask <= next_mask;
      control <= next_control;
      done_pend <= next_done_pend;
    end
  end

  mlsc_mem #(.AW(MEM_AW)) u_mem (
    .clk(I_MCLK),
    .we(req.we),
    .addr(req.we ? req.addr : next_ptr), // write at the pointer, else prefetch
    .wdata(req.wdata),
    .rdata(mem_rdata)
  );

  // output registers
  always_ff @(posedge I_MCLK) begin
    O_PRESENCE_N <= 1'b0; // tied low while inserted
    O_SDA <= 1'b0;
    O_SDA_OE_N <= ~sda_low;
    O_ATTENTION_N <= 1'b0; // only ever pulls low
    // released once nothing unmasked is latched
    O_ATTENTION_OE_N <= any_rst | ~(|(flags & ~mask));
    // software override wins over the pin when enabled
    O_POWER_CAP <= control[CONTROL_LP_OVERRIDE_BIT] ? control[CONTROL_LP_FORCE_BIT] : sync.lp_sel;
    O_IN_RESET <= any_rst | not_ready;
  end
endmodule

// ===== test_module_low_speed_control.sv
`timescale 1ns/1ns
module test_module_low_speed_control import mlsc_pkg::*;;
  localparam int PC = 4;
  logic clk, rst, sel_n, init_n, lp, scl, sda, o_sda, sda_oe_n, pres_n, attn_n, attn_oe_n, cap, in_rst, ack, seen;
  logic [7:1] fault;
  logic [7:0] rd;
  int err_count, compares;
  wire attn = attn_oe_n | attn_n; // host pull-up
  mlsc_top #(.PULSE_CYC(PC)) dut (.I_MCLK(clk), .I_RESET(rst), .I_MODULE_SELECT_N(sel_n), .I_MODULE_INIT_N(init_n),
    .I_LOW_POWER_SELECT(lp), .I_SCL(scl), .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE_N(sda_oe_n), .O_PRESENCE_N(pres_n),
    .O_ATTENTION_N(attn_n), .O_ATTENTION_OE_N(attn_oe_n), .I_FAULT(fault), .O_POWER_CAP(cap), .O_IN_RESET(in_rst));
  mlsc_host host (.dev_sda(o_sda), .dev_sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  task automatic end_of_test();
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // inputs move a fixed 2 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.get(a, rd, ack);
    chk(8'(ack), 8'h01);
    chk(rd, exp);
  endtask
  // status is meaningless until the module reports ready
  task automatic wait_ready();
    for (int i = 0; i < 40 && in_rst !== 1'b0; i++) cyc(1);
    chk(8'(in_rst), 8'h00);
    if (in_rst !== 1'b0) end_of_test();
    cyc(8);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst, sel_n, init_n, lp, fault, err_count, compares} = {4'b1010, 7'h00, 64'd0};
    cyc(8);
    rst = 1'b0;
    wait_ready();
    chk({attn, pres_n}, 8'h00);
    rd_chk(ADDR_STATUS, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h01);
    cyc(8);
    chk(8'(attn), 8'h01);
    host.put(8'h10, 8'ha5, ack);
    chk(8'(ack), 8'h01);
    rd_chk(8'h10, 8'ha5);
    sel_n = 1'b1;
    host.put(8'h10, 8'h5a, ack);
    chk(8'(ack), 8'h00);
    sel_n = 1'b0;
    rd_chk(8'h10, 8'ha5);
    lp = 1'b1;
    cyc(6);
    chk(8'(cap), 8'h01);
    lp = 1'b0;
    cyc(6);
    chk(8'(cap), 8'h00);
    // software override forces the cap with the pin low
    host.put(ADDR_CONTROL, 8'h03, ack);
    cyc(6);
    chk(8'(cap), 8'h01);
    fault = 7'h02;
    cyc(8);
    chk(8'(attn), 8'h00);
    fault = 7'h00;
    rd_chk(ADDR_FLAGS, 8'h04);
    cyc(8);
    chk(8'(attn), 8'h01);
    host.put(ADDR_MASK, 8'h02, ack);
    chk(8'(ack), 8'h01);
    init_n = 1'b0;
    cyc(PC - 2);
    init_n = 1'b1;
    cyc(8);
    chk(8'(in_rst), 8'h00);
    rd_chk(ADDR_MASK, 8'h02);
    seen = 1'b0;
    init_n = 1'b0;
    for (int i = 0; i < PC + 10; i++) begin
      cyc(1);
      seen = seen | in_rst;
    end
    init_n = 1'b1;
    chk(8'(seen), 8'h01);
    wait_ready();
    chk(8'(attn), 8'h00);
    chk(8'(cap), 8'h00);
    rd_chk(ADDR_MASK, MASK_RESET);
    rd_chk(ADDR_FLAGS, 8'h01);
    end_of_test();
  end
endmodule
